// ===== src/rtcf_bcd_step.v
`timescale 1ns/10ps
`default_nettype none

module rtcf_bcd_step (
    input  wire [6:0] value_i,
    input  wire [6:0] max_i,
    input  wire [6:0] min_i,
    input  wire       step_i,
    output reg  [6:0] next_o,
    output reg        carry_o
);

    always @* begin
        next_o  = value_i;
        carry_o = 1'b0;
        if (step_i) begin
            if (value_i == max_i) begin
                next_o  = min_i;
                carry_o = 1'b1;
            end else if (value_i[3:0] == 4'h9) begin
                next_o = {value_i[6:4] + 3'h1, 4'h0};
            end else begin
                next_o = value_i + 7'h01;
            end
        end
    end

endmodule // rtcf_bcd_step

`default_nettype wire

// ===== src/rtcf_regs.vh
`ifndef RTCF_REGS_VH
`define RTCF_REGS_VH

// byte offsets on the register bus
`define RTCF_OFF_MINUTES      5'h00
`define RTCF_OFF_HOURS        5'h04
`define RTCF_OFF_WEEKDAY      5'h08
`define RTCF_OFF_DATE         5'h0C
`define RTCF_OFF_PAGE         5'h10
`define RTCF_OFF_MONTH        5'h14
`define RTCF_OFF_STATUS       5'h18

// field indexes inside the packed field store
`define RTCF_IDX_MINUTES      2'h0
`define RTCF_IDX_HOURS        2'h1
`define RTCF_IDX_WEEKDAY      2'h2
`define RTCF_IDX_DATE         2'h3

// valid-bit masks, upper bits read as zero
`define RTCF_MASK_MINUTES     7'h7F
`define RTCF_MASK_HOURS       7'h3F
`define RTCF_MASK_WEEKDAY     7'h07
`define RTCF_MASK_DATE        7'h3F

// count limits in packed bcd
`define RTCF_MAX_MINUTES      7'h59
`define RTCF_MAX_HOURS_24     7'h23
`define RTCF_MAX_HOURS_12     7'h11
`define RTCF_MAX_WEEKDAY      7'h06
`define RTCF_MAX_DATE         7'h31
`define RTCF_MIN_ZERO         7'h00
`define RTCF_MIN_DATE         7'h01

// field bit positions
`define RTCF_HOUR_PM_BIT      5
`define RTCF_PAGE_SEL_BIT     0
`define RTCF_PAGE_RUN_BIT     3
`define RTCF_FMT_24_BIT       0

// reset values
`define RTCF_RST_TIME         28'h0200000
`define RTCF_RST_ALARM        28'h0000000
`define RTCF_RST_PAGE         1'h0
`define RTCF_RST_RUN          1'h0
`define RTCF_RST_FMT          1'h1

// timing
`define RTCF_CLK_HZ           64'd40000000
`define RTCF_MINUTE_S         64'd60
`define RTCF_MINUTE_CYCLES    (`RTCF_MINUTE_S * `RTCF_CLK_HZ)

`endif

// ===== src/rtcf_time_fields.v
// Local design decisions: the register addresses and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
`include "rtcf_regs.vh"

module rtcf_time_fields #(
    parameter [63:0] MINUTE_CYCLES = `RTCF_MINUTE_CYCLES
) (
    input  wire        sys_clk_i,
    input  wire        reset_n_i,
    input  wire [4:0]  avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    input  wire [3:0]  avs_byteenable_i,
    output wire [31:0] avs_readdata_o,
    output wire        avs_waitrequest_o
);

    // bus handshake state
    reg        wait_reg;
    reg [31:0] readdata_reg;

    // packed field stores, seven bits per field, minutes at the bottom
    reg [27:0] time_fields_reg;
    reg [27:0] alarm_fields_reg;

    // control
    reg        page_reg;
    reg        run_reg;
    reg        fmt_24_reg;

    // minute prescaler and update sequence
    reg [31:0] prescale_reg;
    reg        tick_reg;
    reg [7:0]  update_seq_reg;

    // decode
    wire       is_field;
    wire [1:0] field_idx;
    wire       commit_write;
    wire       accept_read;
    reg  [6:0] field_mask;
    reg  [7:0] read_byte;

    // step chain
    wire [27:0] step_cur;
    wire [27:0] step_max;
    wire [27:0] step_min;
    wire [27:0] step_next;
    wire [3:0]  step_en;
    wire [3:0]  step_carry;
    wire        day_carry;
    wire [6:0]  hour_now;
    wire [6:0]  hour_stepped;
    wire [27:0] time_stepped;

    assign avs_waitrequest_o = wait_reg;
    assign avs_readdata_o    = readdata_reg;

    // fields occupy the four words below the page register
    assign is_field  = (avs_address_i[4] == 1'b0);
    assign field_idx = avs_address_i[3:2];

    // a write lands at the edge where waitrequest is seen low
    assign commit_write = avs_write_i & ~wait_reg & avs_byteenable_i[0];
    assign accept_read  = avs_read_i & wait_reg;

    always @* begin
        case (field_idx)
            `RTCF_IDX_MINUTES: field_mask = `RTCF_MASK_MINUTES;
            `RTCF_IDX_HOURS:   field_mask = `RTCF_MASK_HOURS;
            `RTCF_IDX_WEEKDAY: field_mask = `RTCF_MASK_WEEKDAY;
            `RTCF_IDX_DATE:    field_mask = `RTCF_MASK_DATE;
            default:           field_mask = 7'h00;
        endcase
    end

    // one waitrequest cycle per access, then release
    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wait_reg <= 1'b1;
        end else if (!wait_reg) begin
            wait_reg <= 1'b1;
        end else if (avs_read_i || avs_write_i) begin
            wait_reg <= 1'b0;
        end
    end

    // read mux: the selected page decides which store answers
    always @* begin
        read_byte = 8'h00;
        if (is_field) begin
            if (page_reg) begin
                read_byte = {1'b0, alarm_fields_reg[7*field_idx +: 7] & field_mask};
            end else begin
                read_byte = {1'b0, time_fields_reg[7*field_idx +: 7] & field_mask};
            end
        end else begin
            case (avs_address_i)
                `RTCF_OFF_PAGE: begin
                    read_byte = 8'h00;
                    read_byte[`RTCF_PAGE_SEL_BIT] = page_reg;
                    read_byte[`RTCF_PAGE_RUN_BIT] = run_reg;
                end
                `RTCF_OFF_MONTH: begin
                    // no month counting here; the time page reads zero
                    read_byte = 8'h00;
                    read_byte[`RTCF_FMT_24_BIT] = page_reg & fmt_24_reg;
                end
                `RTCF_OFF_STATUS: begin
                    read_byte = update_seq_reg;
                end
                default: begin
                    read_byte = 8'h00;
                end
            endcase
        end
    end

    // read data captured as the request is accepted, stands one cycle later
    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            readdata_reg <= 32'h00000000;
        end else if (accept_read) begin
            readdata_reg <= {24'h000000, read_byte};
        end
    end

    // control registers
    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            page_reg   <= `RTCF_RST_PAGE;
            run_reg    <= `RTCF_RST_RUN;
            fmt_24_reg <= `RTCF_RST_FMT;
        end else if (commit_write) begin
            if (avs_address_i == `RTCF_OFF_PAGE) begin
                page_reg <= avs_writedata_i[`RTCF_PAGE_SEL_BIT];
                run_reg  <= avs_writedata_i[`RTCF_PAGE_RUN_BIT];
            end
            // format is taken as written; changing it while running is the caller's fault
            if (avs_address_i == `RTCF_OFF_MONTH && page_reg) begin
                fmt_24_reg <= avs_writedata_i[`RTCF_FMT_24_BIT];
            end
        end
    end

    // minute prescaler; held in reset while stopped so a start begins a full minute
    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prescale_reg <= 32'h00000000;
            tick_reg     <= 1'b0;
        end else if (!run_reg) begin
            prescale_reg <= 32'h00000000;
            tick_reg     <= 1'b0;
        end else if ({32'h00000000, prescale_reg} == MINUTE_CYCLES - 64'h1) begin
            prescale_reg <= 32'h00000000;
            tick_reg     <= 1'b1;
        end else begin
            prescale_reg <= prescale_reg + 32'h00000001;
            tick_reg     <= 1'b0;
        end
    end

    // in 12 hour form only the low five bits count, the pm flag toggles on wrap
    assign hour_now = time_fields_reg[13:7];

    assign step_cur = {time_fields_reg[27:14],
                       fmt_24_reg ? hour_now : {2'b00, hour_now[4:0]},
                       time_fields_reg[6:0]};

    assign step_max = {`RTCF_MAX_DATE,
                       `RTCF_MAX_WEEKDAY,
                       fmt_24_reg ? `RTCF_MAX_HOURS_24 : `RTCF_MAX_HOURS_12,
                       `RTCF_MAX_MINUTES};

    assign step_min = {`RTCF_MIN_DATE,
                       `RTCF_MIN_ZERO,
                       `RTCF_MIN_ZERO,
                       `RTCF_MIN_ZERO};

    // carry chain: minute -> hour -> weekday and date together
    assign step_en[0] = tick_reg;
    assign step_en[1] = step_carry[0];
    assign day_carry  = fmt_24_reg ? step_carry[1]
                                   : (step_carry[1] & hour_now[`RTCF_HOUR_PM_BIT]);
    assign step_en[2] = day_carry;
    assign step_en[3] = day_carry;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_field
            rtcf_bcd_step u_step (
                .value_i (step_cur[7*gi +: 7]),
                .max_i   (step_max[7*gi +: 7]),
                .min_i   (step_min[7*gi +: 7]),
                .step_i  (step_en[gi]),
                .next_o  (step_next[7*gi +: 7]),
                .carry_o (step_carry[gi])
            );
        end
    endgenerate

    assign hour_stepped = fmt_24_reg ? step_next[13:7]
                        : {1'b0,
                           hour_now[`RTCF_HOUR_PM_BIT] ^ step_carry[1],
                           step_next[11:7]};

    // date wraps at 31 regardless of month; month length is not tracked
    assign time_stepped = {step_next[27:14], hour_stepped, step_next[6:0]};

    // live time store; a software write in the tick cycle overrides the count
    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            time_fields_reg <= `RTCF_RST_TIME;
        end else begin
            if (tick_reg) begin
                time_fields_reg <= time_stepped;
            end
            if (commit_write && is_field && !page_reg) begin
                time_fields_reg[7*field_idx +: 7] <= avs_writedata_i[6:0] & field_mask;
            end
        end
    end

    // alarm compare values, never counted
    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            alarm_fields_reg <= `RTCF_RST_ALARM;
        end else if (commit_write && is_field && page_reg) begin
            alarm_fields_reg[7*field_idx +: 7] <= avs_writedata_i[6:0] & field_mask;
        end
    end

    // bumps on every count update so a double read can spot a torn value
    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            update_seq_reg <= 8'h00;
        end else if (tick_reg) begin
            update_seq_reg <= update_seq_reg + 8'h01;
        end
    end

endmodule // rtcf_time_fields

`default_nettype wire

// ===== verif/rtcf_time_fields_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "rtcf_regs.vh"
module rtcf_time_fields_checker #(
    parameter [63:0] MINUTE_CYCLES = 64'd8
) (
    input wire logic        sys_clk_i,
    input wire logic        reset_n_i,
    input wire logic [4:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0]  avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    sequence s_req;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence s_ans;
        !avs_waitrequest_o ##1 avs_waitrequest_o;
    endsequence
    sequence s_rd(logic [4:0] a);
        avs_read_i && !avs_waitrequest_o && avs_address_i == a;
    endsequence
    property p_answer;
        s_req |=> s_ans;
    endproperty
    property p_idle;
        !avs_read_i && !avs_write_i && avs_waitrequest_o |=> avs_waitrequest_o;
    endproperty
    property p_reset;
        $rose(reset_n_i) |-> avs_waitrequest_o && avs_readdata_o == 32'h0;
    endproperty
    property p_min_top;
        s_rd(`RTCF_OFF_MINUTES) |-> avs_readdata_o[31:7] == 25'h0;
    endproperty
    property p_min_range;
        s_rd(`RTCF_OFF_MINUTES) |-> avs_readdata_o[7:0] <= 8'h59;
    endproperty
    property p_hour_top;
        s_rd(`RTCF_OFF_HOURS) |-> avs_readdata_o[31:6] == 26'h0;
    endproperty
    property p_hour_range;
        s_rd(`RTCF_OFF_HOURS) |-> avs_readdata_o[7:0] <= 8'h31;
    endproperty
    property p_wday;
        s_rd(`RTCF_OFF_WEEKDAY) |-> avs_readdata_o[31:3] == 29'h0 && avs_readdata_o[2:0] != 3'h7;
    endproperty
    property p_date_top;
        s_rd(`RTCF_OFF_DATE) |-> avs_readdata_o[31:6] == 26'h0;
    endproperty
    a_answer: assert property (p_answer) else $error("answer not one wait cycle");
    a_idle: assert property (p_idle) else $error("answer without request");
    a_reset: assert property (p_reset) else $error("bus not idle after reset");
    a_min_top: assert property (p_min_top) else $error("minutes top bit set");
    a_min_range: assert property (p_min_range) else $error("minutes out of range");
    a_hour_top: assert property (p_hour_top) else $error("hours bits 7..6 set");
    a_hour_range: assert property (p_hour_range) else $error("hours out of range");
    a_wday: assert property (p_wday) else $error("weekday bad code");
    a_date_top: assert property (p_date_top) else $error("date bits 7..6 set");
endmodule // rtcf_time_fields_checker
bind rtcf_time_fields rtcf_time_fields_checker #(.MINUTE_CYCLES(MINUTE_CYCLES)) u_chk (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o));
`default_nettype wire

// ===== verif/rtcf_time_fields_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "rtcf_regs.vh"
module rtcf_time_fields_tb;
    logic        sys_clk_i  = 1'b0;
    logic        reset_n_i  = 1'b0;
    logic [4:0]  adr        = 5'h00;
    logic        rd         = 1'b0;
    logic        wr         = 1'b0;
    logic [31:0] wd         = 32'h0;
    logic [3:0]  be         = 4'hF;
    wire  [31:0] rdat;
    wire         waitreq;
    logic [31:0] q;
    int          num_errors = 0;
    int          tests_run  = 0;
    always #12.5 sys_clk_i = ~sys_clk_i;
    // short minute keeps roll-over runs brief
    rtcf_time_fields #(.MINUTE_CYCLES(64'd8)) dut (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
        .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(waitreq));
    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
        int n;
        @(posedge sys_clk_i);
        adr <= a;
        wd  <= {24'h0, d};
        wr  <= w;
        rd  <= ~w;
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (waitreq !== 1'b0 && n < 64);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 64) begin
            num_errors++;
            finish_test;
        end
    endtask
    task automatic rc(input string nm, input logic [4:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        tests_run++;
        if (q !== {24'h0, e}) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, {24'h0, e}, q);
        end
    endtask
    task automatic fill(input logic [7:0] m, h, w, d);
        bus(1'b1, `RTCF_OFF_MINUTES, m);
        bus(1'b1, `RTCF_OFF_HOURS, h);
        bus(1'b1, `RTCF_OFF_WEEKDAY, w);
        bus(1'b1, `RTCF_OFF_DATE, d);
    endtask
    task automatic rd4(input logic [7:0] m, h, w, d);
        rc("minutes", `RTCF_OFF_MINUTES, m);
        rc("hours", `RTCF_OFF_HOURS, h);
        rc("weekday", `RTCF_OFF_WEEKDAY, w);
        rc("date", `RTCF_OFF_DATE, d);
    endtask
    // stop right after the first tick so exactly one minute is counted
    task automatic tick1;
        logic [31:0] s0;
        int          n;
        bus(1'b0, `RTCF_OFF_STATUS, 8'h00);
        s0 = q;
        bus(1'b1, `RTCF_OFF_PAGE, 8'h08);
        n = 0;
        do begin
            bus(1'b0, `RTCF_OFF_STATUS, 8'h00);
            n++;
        end while (q === s0 && n < 40);
        bus(1'b1, `RTCF_OFF_PAGE, 8'h00);
        if (q === s0) begin
            num_errors++;
            finish_test;
        end
    endtask
    task automatic roll(input logic f24, input logic [7:0] m, h, w, d, em, eh, ew, ed);
        bus(1'b1, `RTCF_OFF_PAGE, 8'h01);
        bus(1'b1, `RTCF_OFF_MONTH, {7'h00, f24});
        bus(1'b1, `RTCF_OFF_PAGE, 8'h00);
        fill(m, h, w, d);
        tick1;
        rd4(em, eh, ew, ed);
        $display("test roll done");
    endtask
    initial begin
        repeat (12) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        rd4(8'h00, 8'h00, 8'h00, 8'h01);
        $display("test reset done");
        fill(8'h59, 8'h23, 8'h06, 8'h31);
        bus(1'b1, `RTCF_OFF_PAGE, 8'h01);
        rc("page", `RTCF_OFF_PAGE, 8'h01);
        fill(8'h12, 8'h11, 8'h03, 8'h17);
        rd4(8'h12, 8'h11, 8'h03, 8'h17);
        rc("alarm month", `RTCF_OFF_MONTH, 8'h01);
        bus(1'b1, `RTCF_OFF_PAGE, 8'h00);
        rd4(8'h59, 8'h23, 8'h06, 8'h31);
        be <= 4'h0;
        bus(1'b1, `RTCF_OFF_MINUTES, 8'h42);
        be <= 4'hF;
        rc("disabled write", `RTCF_OFF_MINUTES, 8'h59);
        bus(1'b1, 5'h1C, 8'h33);
        rc("unmapped", 5'h1C, 8'h00);
        rc("time month", `RTCF_OFF_MONTH, 8'h00);
        $display("test pages done");
        roll(1'b1, 8'h59, 8'h23, 8'h06, 8'h31, 8'h00, 8'h00, 8'h00, 8'h01);
        roll(1'b1, 8'h09, 8'h09, 8'h02, 8'h09, 8'h10, 8'h09, 8'h02, 8'h09);
        roll(1'b1, 8'h59, 8'h09, 8'h02, 8'h09, 8'h00, 8'h10, 8'h02, 8'h09);
        roll(1'b0, 8'h59, 8'h31, 8'h05, 8'h15, 8'h00, 8'h00, 8'h06, 8'h16);
        roll(1'b0, 8'h59, 8'h11, 8'h05, 8'h15, 8'h00, 8'h20, 8'h05, 8'h15);
        // second reset in mid-run must bring back the start values and 24 hour form
        reset_n_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        rd4(8'h00, 8'h00, 8'h00, 8'h01);
        rc("page after reset", `RTCF_OFF_PAGE, 8'h00);
        bus(1'b1, `RTCF_OFF_PAGE, 8'h01);
        rc("format after reset", `RTCF_OFF_MONTH, 8'h01);
        bus(1'b1, `RTCF_OFF_PAGE, 8'h00);
        $display("test second reset done");
        finish_test;
    end
endmodule // rtcf_time_fields_tb
`default_nettype wire
